// ### rtl/spr_serial_port_unit.sv
// Serial port unit: pin roles, select modes, shift logic and APB register file.
//
// The implementer's own choices: the register offsets and the APB slave port.
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - Master drives master-out; slave reads it.
// - Master samples master-in; slave drives it.
// - Both directions shift most significant bit first.
// - Master-out carries shift register MSB.
// - Slave-out floats when disabled or unselected.
// - Three-wire slave always drives shift MSB.
// - Serial clock driven only as master.
// - Unselected four-wire slave ignores serial clock.
// - Mode 00: three-wire, slave always selected.
// - Mode 01: select input chooses slave.
// - Mode 01 master: select fall disables master.
// - Mode 1x: select output equals lower bit.
// - Select pin routed except in mode 00.
// - Master enable bit picks master or slave.
// - Select fault clears enables, sets flag.
module spr_serial_port_unit (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe_n,
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe_n,
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe_n,
  input wire logic slave_select_n_i,
  output logic slave_select_n_o,
  output logic slave_select_n_oe_n,
  output logic select_pin_routed
);

  // ----------------------------------------------------------------
  // Declarations.
  // ----------------------------------------------------------------
  spr_pkg::spr_ctrl_type ctrl_q;
  logic [1:0] status_q;
  logic [1:0] mask_q;
  logic [7:0] tx_buf_q;
  logic tx_full_q;
  logic [7:0] rx_q;
  logic [7:0] shreg_q;
  logic bit_q;
  logic [3:0] cnt_q;
  logic active_q;
  logic [3:0] div_q;
  logic sck_q;
  logic [2:0] sck_sync_q;
  logic [2:0] nss_sync_q;
  logic [1:0] mosi_sync_q;
  logic [1:0] miso_sync_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic irq_q;
  logic mosi_o_q;
  logic mosi_oe_n_q;
  logic miso_o_q;
  logic miso_oe_n_q;
  logic sck_oe_n_q;
  logic nss_o_q;
  logic nss_oe_n_q;
  logic routed_q;
  logic enabled;
  logic master;
  logic [1:0] sel_mode;
  logic selected;
  logic nss_fall;
  logic fault;
  logic tick;
  logic rise;
  logic fall;
  logic din;
  logic complete;
  logic wr_en;
  logic rd_en;
  logic mapped;

  // Address decode shared by read and write paths.
  function automatic logic spr_is_mapped(input logic [7:0] addr);
    spr_is_mapped = (addr == spr_pkg::SPR_CTRL_OFFSET) || (addr == spr_pkg::SPR_STATUS_OFFSET) ||
                    (addr == spr_pkg::SPR_MASK_OFFSET) || (addr == spr_pkg::SPR_DATA_OFFSET);
  endfunction

  // ----------------------------------------------------------------
  // Input synchronisers.
  // ----------------------------------------------------------------

  // Every pin passes two flops; the third stage only serves edge detection.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sck_sync_q <= 3'h0;
      nss_sync_q <= 3'h7;
      mosi_sync_q <= 2'h0;
      miso_sync_q <= 2'h0;
    end
    else
    begin
      sck_sync_q <= {sck_sync_q[1:0], sck_i};
      nss_sync_q <= {nss_sync_q[1:0], slave_select_n_i};
      mosi_sync_q <= {mosi_sync_q[0], mosi_i};
      miso_sync_q <= {miso_sync_q[0], miso_i};
    end
  end

  // ----------------------------------------------------------------
  // Mode decode.
  // ----------------------------------------------------------------

  // Master role requires the port to be enabled as well.
  assign enabled = ctrl_q.port_enable_bit;
  assign master = ctrl_q.port_enable_bit && ctrl_q.master_enable_bit;
  assign sel_mode = {ctrl_q.select_mode_upper_bit, ctrl_q.select_mode_lower_bit};
  assign nss_fall = nss_sync_q[2] && !nss_sync_q[1];
  assign fault = master && (sel_mode == spr_pkg::SPR_SEL_FOUR_WIRE_IN) && nss_fall;

  // A slave in output-select mode is treated as unselected, which keeps it off the bus.
  always_comb
  begin
    case (sel_mode)
      spr_pkg::SPR_SEL_THREE_WIRE: selected = 1'b1;
      spr_pkg::SPR_SEL_FOUR_WIRE_IN: selected = !nss_sync_q[1];
      default: selected = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Serial clock events.
  // ----------------------------------------------------------------

  // Master divider runs only while a byte is in flight.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_q <= 4'h0;
      sck_q <= 1'b0;
    end
    else if (!master || !active_q)
    begin
      div_q <= 4'h0;
      sck_q <= 1'b0;
    end
    else if (tick)
    begin
      div_q <= 4'h0;
      sck_q <= !sck_q;
    end
    else
    begin
      div_q <= div_q + 4'h1;
    end
  end

  assign tick = master && active_q && (div_q == spr_pkg::SPR_SCK_HALF_LAST);

  // Slave edges count only while selected, so a deselected slave never shifts.
  always_comb
  begin
    if (master)
    begin
      rise = tick && !sck_q;
      fall = tick && sck_q;
      din = miso_sync_q[1];
    end
    else
    begin
      rise = enabled && selected && !sck_sync_q[2] && sck_sync_q[1];
      fall = enabled && selected && sck_sync_q[2] && !sck_sync_q[1];
      din = mosi_sync_q[1];
    end
  end

  assign complete = fall && (cnt_q == spr_pkg::SPR_BITS_PER_BYTE);

  // ----------------------------------------------------------------
  // Shift engine.
  // ----------------------------------------------------------------

  // Bits are caught on the rising edge and shifted in at the LSB on the falling edge, so the
  // MSB leaves first and stays put for the whole high phase.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      shreg_q <= spr_pkg::SPR_BYTE_RESET;
      bit_q <= 1'b0;
      cnt_q <= 4'h0;
      active_q <= 1'b0;
      rx_q <= spr_pkg::SPR_BYTE_RESET;
    end
    else if (!enabled)
    begin
      cnt_q <= 4'h0;
      active_q <= 1'b0;
    end
    else
    begin
      if (!master && (sel_mode == spr_pkg::SPR_SEL_FOUR_WIRE_IN) && nss_fall)
      begin
        cnt_q <= 4'h0;
      end
      else if (rise)
      begin
        bit_q <= din;
        cnt_q <= cnt_q + 4'h1;
      end
      else if (complete)
      begin
        rx_q <= {shreg_q[6:0], bit_q};
        cnt_q <= 4'h0;
        active_q <= 1'b0;
      end
      else if (fall)
      begin
        shreg_q <= {shreg_q[6:0], bit_q};
      end
      if (!active_q && tx_full_q)
      begin
        shreg_q <= tx_buf_q;
        active_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // APB slave.
  // ----------------------------------------------------------------

  // One wait state: the answer is registered so that all bus outputs come from flops.
  assign mapped = spr_is_mapped(paddr);
  assign wr_en = psel && penable && pready_q && pwrite && mapped;
  assign rd_en = psel && penable && !pready_q && !pwrite;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end
    else
    begin
      pready_q <= psel && penable && !pready_q;
      pslverr_q <= psel && penable && !pready_q && !mapped;
      if (rd_en)
      begin
        case (paddr)
          spr_pkg::SPR_CTRL_OFFSET: prdata_q <= {28'h000_0000, ctrl_q};
          spr_pkg::SPR_STATUS_OFFSET: prdata_q <= {30'h0000_0000, status_q};
          spr_pkg::SPR_MASK_OFFSET: prdata_q <= {30'h0000_0000, mask_q};
          spr_pkg::SPR_DATA_OFFSET: prdata_q <= {24'h00_0000, rx_q};
          default: prdata_q <= 32'h0000_0000;
        endcase
      end
      else if (!(psel && penable))
      begin
        prdata_q <= 32'h0000_0000;
      end
    end
  end

  // A fault in the same cycle as a control write wins, so the bus cannot re-arm a faulted master.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= spr_pkg::SPR_CTRL_RESET;
    end
    else if (fault)
    begin
      ctrl_q.master_enable_bit <= 1'b0;
      ctrl_q.port_enable_bit <= 1'b0;
    end
    else if (wr_en && (paddr == spr_pkg::SPR_CTRL_OFFSET))
    begin
      ctrl_q <= pwdata[3:0];
    end
  end

  // Sticky status: hardware set beats a write-one clear in the same cycle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status_q <= spr_pkg::SPR_STATUS_RESET;
      mask_q <= spr_pkg::SPR_MASK_RESET;
    end
    else
    begin
      if (wr_en && (paddr == spr_pkg::SPR_MASK_OFFSET))
      begin
        mask_q <= pwdata[1:0];
      end
      status_q[spr_pkg::SPR_STAT_DONE_POS] <= complete ||
        (status_q[spr_pkg::SPR_STAT_DONE_POS] &&
         !(wr_en && (paddr == spr_pkg::SPR_STATUS_OFFSET) && pwdata[spr_pkg::SPR_STAT_DONE_POS]));
      status_q[spr_pkg::SPR_STAT_FAULT_POS] <= fault ||
        (status_q[spr_pkg::SPR_STAT_FAULT_POS] &&
         !(wr_en && (paddr == spr_pkg::SPR_STATUS_OFFSET) && pwdata[spr_pkg::SPR_STAT_FAULT_POS]));
    end
  end

  // Transmit holding register; a write while it is still full is dropped.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_buf_q <= spr_pkg::SPR_BYTE_RESET;
      tx_full_q <= 1'b0;
    end
    else if (wr_en && (paddr == spr_pkg::SPR_DATA_OFFSET) && !tx_full_q)
    begin
      tx_buf_q <= pwdata[7:0];
      tx_full_q <= 1'b1;
    end
    else if (!enabled || !active_q)
    begin
      // The buffer empties here: with the port enabled the shift engine takes the byte at this same edge; with it disabled the byte is dropped.
      tx_full_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Registered pin drivers.
  // ----------------------------------------------------------------

  // Enables are low while driving; all follow the mode one cycle later.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mosi_o_q <= 1'b0;
      mosi_oe_n_q <= 1'b1;
      miso_o_q <= 1'b0;
      miso_oe_n_q <= 1'b1;
      sck_oe_n_q <= 1'b1;
      nss_o_q <= 1'b1;
      nss_oe_n_q <= 1'b1;
      routed_q <= 1'b1;
      irq_q <= 1'b0;
    end
    else
    begin
      mosi_o_q <= master && shreg_q[7];
      mosi_oe_n_q <= !master;
      miso_o_q <= shreg_q[7];
      miso_oe_n_q <= !(enabled && !master && selected);
      sck_oe_n_q <= !master;
      nss_o_q <= ctrl_q.select_mode_lower_bit;
      nss_oe_n_q <= !ctrl_q.select_mode_upper_bit;
      routed_q <= sel_mode != spr_pkg::SPR_SEL_THREE_WIRE;
      irq_q <= |(status_q & mask_q);
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irq = irq_q;
  assign mosi_o = mosi_o_q;
  assign mosi_oe_n = mosi_oe_n_q;
  assign miso_o = miso_o_q;
  assign miso_oe_n = miso_oe_n_q;
  assign sck_o = sck_q;
  assign sck_oe_n = sck_oe_n_q;
  assign slave_select_n_o = nss_o_q;
  assign slave_select_n_oe_n = nss_oe_n_q;
  assign select_pin_routed = routed_q;

  // ----------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_mosi_role: assert property (##1 mosi_oe_n == !$past(master))
    else $error("master-out enable does not follow role");
  chk_miso_role: assert property (enabled && !master && selected |=> !miso_oe_n)
    else $error("selected slave does not drive master-in");
  chk_msb_out: assert property (master |=> mosi_o == $past(shreg_q[7]))
    else $error("master-out is not the shift MSB");
  chk_miso_float: assert property (!enabled || (!master && !selected) |=> miso_oe_n)
    else $error("slave-out driven while disabled or unselected");
  chk_three_wire: assert property (enabled && !master && sel_mode == 2'b00 |=> !miso_oe_n && miso_o == $past(shreg_q[7]))
    else $error("three-wire slave does not drive shift MSB");
  chk_sck_role: assert property (!master |=> !sck_o && sck_oe_n)
    else $error("serial clock driven outside master role");
  chk_sck_ignore: assert property (!master && sel_mode == 2'b01 && nss_sync_q[1] |=> $stable(shreg_q) || $past(!active_q))
    else $error("unselected slave shifted");
  chk_fault_clear: assert property (fault |=> !ctrl_q.master_enable_bit && !ctrl_q.port_enable_bit && status_q[1])
    else $error("select fault did not disable master");
  chk_select_out: assert property (sel_mode[1] |=> !slave_select_n_oe_n && slave_select_n_o == $past(sel_mode[0]))
    else $error("select output level wrong");
  chk_pin_route: assert property (##1 select_pin_routed == ($past(sel_mode) != 2'b00))
    else $error("select pin routing wrong");
  chk_sync_fault: assert property (fault |-> $past(slave_select_n_i, 3) && !$past(slave_select_n_i, 2))
    else $error("fault raised without synchronised select fall");

  cov_master_byte: cover property (master && complete);
  cov_slave_byte: cover property (!master && complete);
  cov_fault: cover property (fault);
  cov_irq: cover property (irq);

endmodule

`default_nettype wire

// ### rtl/spr_pkg.sv
// Package with register map, field layout, reset values and timing for the serial port unit.
package spr_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets on the APB bus.
  // ----------------------------------------------------------------
  localparam logic [7:0] SPR_CTRL_OFFSET = 8'h00;
  localparam logic [7:0] SPR_STATUS_OFFSET = 8'h04;
  localparam logic [7:0] SPR_MASK_OFFSET = 8'h08;
  localparam logic [7:0] SPR_DATA_OFFSET = 8'h0C;

  // ----------------------------------------------------------------
  // Field positions.
  // ----------------------------------------------------------------
  localparam int SPR_CTRL_PORT_EN_POS = 0;
  localparam int SPR_CTRL_MASTER_EN_POS = 1;
  localparam int SPR_CTRL_SEL_LOWER_POS = 2;
  localparam int SPR_CTRL_SEL_UPPER_POS = 3;
  localparam int SPR_STAT_DONE_POS = 0;
  localparam int SPR_STAT_FAULT_POS = 1;

  // ----------------------------------------------------------------
  // Reset values. Select mode resets to 01, the four-wire input mode.
  // ----------------------------------------------------------------
  localparam logic [3:0] SPR_CTRL_RESET = 4'h4;
  localparam logic [1:0] SPR_STATUS_RESET = 2'h0;
  localparam logic [1:0] SPR_MASK_RESET = 2'h0;
  localparam logic [7:0] SPR_BYTE_RESET = 8'h00;
  localparam logic [3:0] SPR_BITS_PER_BYTE = 4'h8;

  // ----------------------------------------------------------------
  // Serial clock timing for master mode.
  // ----------------------------------------------------------------
  localparam int SPR_PCLK_NS = 40;
  localparam int SPR_SCK_HALF_NS = 160;
  localparam int SPR_SCK_HALF_CYCLES = (SPR_SCK_HALF_NS + SPR_PCLK_NS - 1) / SPR_PCLK_NS;
  localparam logic [3:0] SPR_SCK_HALF_LAST = 4'(SPR_SCK_HALF_CYCLES - 1);

  // ----------------------------------------------------------------
  // Select mode encodings and control carrier.
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SPR_SEL_THREE_WIRE = 2'b00,
    SPR_SEL_FOUR_WIRE_IN = 2'b01,
    SPR_SEL_OUT_LOW = 2'b10,
    SPR_SEL_OUT_HIGH = 2'b11
  } spr_sel_mode_type;

  typedef struct packed {
    logic select_mode_upper_bit;
    logic select_mode_lower_bit;
    logic master_enable_bit;
    logic port_enable_bit;
  } spr_ctrl_type;

endpackage

// ### bench/spr_far_end.sv
// Far-end link partner: a serial master or slave device facing the port unit.
`timescale 1ns/10ps
`default_nettype none
module spr_far_end (
  input wire logic sck_w,
  input wire logic mosi_w,
  input wire logic miso_w,
  output logic sck_d,
  output logic mosi_d,
  output logic miso_d,
  output logic nss_d,
  output logic nss_en,
  output logic mst_en,
  output logic slv_en
);
  logic [7:0] sh_q;
  logic [7:0] rx_q;

  // Everything idle: no line driven until a scenario asks for it.
  initial
  begin
    {mst_en, slv_en, nss_en, sck_d, mosi_d, sh_q, rx_q} = '0;
    nss_d = 1'b1;
  end

  // ------------------------------------------------------------
  // Slave role: sample on the rise, shift on the fall.
  // ------------------------------------------------------------
  assign miso_d = sh_q[7];
  always @(posedge sck_w)
  begin
    if (slv_en)
      rx_q = {rx_q[6:0], mosi_w};
  end
  always @(negedge sck_w)
  begin
    if (slv_en)
      sh_q = {sh_q[6:0], 1'b0};
  end

  task automatic set_slave(input logic on, input logic [7:0] b);
    slv_en = on;
    sh_q = b;
  endtask

  // The select pin is moved off the system clock edge to keep the sampling race-free.
  task automatic drive_sel(input logic en, input logic lvl);
    #10;
    nss_en = en;
    nss_d = lvl;
  endtask

  // ------------------------------------------------------------
  // Master role: the clock stands low outside frames, 320 ns period.
  // ------------------------------------------------------------
  task automatic xfer(input logic [7:0] tx, input logic sel, output logic [7:0] rx);
    int i;
    #10;
    mst_en = 1'b1;
    nss_en = 1'b1;
    nss_d = ~sel;
    #200;
    for (i = 7; i >= 0; i--)
    begin
      mosi_d = tx[i];
      #160 sck_d = 1'b1;
      rx = {rx[6:0], miso_w};
      #160 sck_d = 1'b0;
    end
    #200 nss_d = 1'b1;
    {mst_en, nss_en} = 2'b00;
  endtask
endmodule
`default_nettype wire

// ### bench/test_spi_pin_role_and_select_modes.sv
// Self-checking bench for the serial port pin-role and select-mode logic.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin errors++; $display("ERROR %0t got %h exp %h", $time, g, e); end end
module test_spi_pin_role_and_select_modes;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic [7:0] paddr, tx, b, got;
  logic [31:0] pwdata, prdata, rd;
  logic mosi_o, mosi_oe_n, miso_o, miso_oe_n, sck_o, sck_oe_n;
  logic slave_select_n_o, slave_select_n_oe_n, select_pin_routed;
  logic f_sck, f_mosi, f_miso, f_nss, f_nss_en, f_mst, f_slv;
  wire logic sck_w, mosi_w, miso_w, nss_w;
  int errors, n_checks, m;
  // Reference model: bytes the far end sends, in the order the port must receive them.
  logic [7:0] exp_q[$];

  // Each line follows whoever enables it; the clock line is pulled low, the others high.
  assign sck_w = !sck_oe_n ? sck_o : f_mst ? f_sck : 1'b0;
  assign mosi_w = !mosi_oe_n ? mosi_o : f_mst ? f_mosi : 1'b1;
  assign miso_w = !miso_oe_n ? miso_o : f_slv ? f_miso : 1'b1;
  assign nss_w = !slave_select_n_oe_n ? slave_select_n_o : f_nss_en ? f_nss : 1'b1;

  spr_serial_port_unit dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq,
    .mosi_i(mosi_w), .mosi_o, .mosi_oe_n, .miso_i(miso_w), .miso_o, .miso_oe_n, .sck_i(sck_w), .sck_o,
    .sck_oe_n, .slave_select_n_i(nss_w), .slave_select_n_o, .slave_select_n_oe_n, .select_pin_routed
  );
  spr_far_end far (
    .sck_w, .mosi_w, .miso_w, .sck_d(f_sck), .mosi_d(f_mosi), .miso_d(f_miso), .nss_d(f_nss),
    .nss_en(f_nss_en), .mst_en(f_mst), .slv_en(f_slv)
  );

  // ------------------------------------------------------------
  // Clock, closing report and bus tasks.
  // ------------------------------------------------------------
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic wt(input int k);
    repeat (k) @(posedge pclk);
  endtask

  // One APB transfer, entered just after a rising edge; the request holds until pready.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      errors++;
      wrap_up();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Waits for the interrupt line with a bound, since a lost transfer must not hang the run.
  task automatic wirq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 2000)
    begin
      @(posedge pclk);
      n++;
    end
    if (n == 2000)
    begin
      errors++;
      wrap_up();
    end
  endtask

  initial
  begin
    #1000000;
    errors++;
    wrap_up();
  end

  // ------------------------------------------------------------
  // Main sequence.
  // ------------------------------------------------------------
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    presetn = 1'b0;
    void'($urandom(77393));
    wt(4);
    `CHK({mosi_oe_n, miso_oe_n, sck_oe_n, slave_select_n_oe_n, irq}, 5'b11110)
    presetn <= 1'b1;
    wt(1);
    apb(0, spr_pkg::SPR_CTRL_OFFSET, 32'h0000_0000);
    `CHK(rd[3:0], spr_pkg::SPR_CTRL_RESET)
    apb(0, 8'h10, 32'h0000_0000);
    `CHK({err, rd}, {1'b1, 32'h0000_0000})
    // Every select mode with the port disabled: routing and select output level.
    for (m = 0; m < 4; m++)
    begin
      apb(1, spr_pkg::SPR_CTRL_OFFSET, 32'(m << 2));
      wt(2);
      `CHK(select_pin_routed, 1'(m != 0))
      `CHK({slave_select_n_oe_n, miso_oe_n}, {1'(m < 2), 1'b1})
      if (m > 1)
        `CHK(slave_select_n_o, 1'(m & 1))
    end
    // Master bytes in three-wire and four-wire output mode against a slave partner.
    apb(1, spr_pkg::SPR_MASK_OFFSET, 32'h0000_0003);
    for (m = 0; m < 4; m += 2)
    begin
      b = 8'($urandom);
      tx = 8'($urandom);
      exp_q.push_back(b);
      far.set_slave(1'b1, b);
      apb(1, spr_pkg::SPR_CTRL_OFFSET, 32'((m << 2) | 3));
      wt(2);
      `CHK({mosi_oe_n, miso_oe_n, sck_oe_n}, 3'b010)
      apb(1, spr_pkg::SPR_DATA_OFFSET, {24'h00_0000, tx});
      wirq();
      `CHK(far.rx_q, tx)
      apb(0, spr_pkg::SPR_DATA_OFFSET, 32'h0000_0000);
      `CHK(rd[7:0], exp_q.pop_front())
      apb(1, spr_pkg::SPR_STATUS_OFFSET, 32'h0000_0001);
      wt(2);
      `CHK({irq, sck_o}, 2'b00)
    end
    far.set_slave(1'b0, 8'h00);
    // Three-wire slave: always selected, slave-out always driven.
    apb(1, spr_pkg::SPR_CTRL_OFFSET, 32'h0000_0001);
    tx = 8'($urandom);
    b = 8'($urandom);
    apb(1, spr_pkg::SPR_DATA_OFFSET, {24'h00_0000, tx});
    wt(2);
    `CHK({mosi_oe_n, miso_oe_n, sck_oe_n}, 3'b101)
    exp_q.push_back(b);
    far.xfer(b, 1'b0, got);
    @(posedge pclk);
    `CHK(got, tx)
    apb(0, spr_pkg::SPR_DATA_OFFSET, 32'h0000_0000);
    `CHK(rd[7:0], exp_q.pop_front())
    apb(1, spr_pkg::SPR_STATUS_OFFSET, 32'h0000_0001);
    // Four-wire slave: clocks while unselected are ignored, then a selected byte.
    apb(1, spr_pkg::SPR_CTRL_OFFSET, 32'h0000_0005);
    tx = 8'($urandom);
    apb(1, spr_pkg::SPR_DATA_OFFSET, {24'h00_0000, tx});
    wt(2);
    `CHK(miso_oe_n, 1'b1)
    far.xfer(8'h5A, 1'b0, got);
    @(posedge pclk);
    apb(0, spr_pkg::SPR_STATUS_OFFSET, 32'h0000_0000);
    `CHK(rd[0], 1'b0)
    far.drive_sel(1'b1, 1'b0);
    wt(6);
    `CHK(miso_oe_n, 1'b0)
    b = 8'($urandom);
    exp_q.push_back(b);
    far.xfer(b, 1'b1, got);
    @(posedge pclk);
    `CHK(got, tx)
    apb(0, spr_pkg::SPR_DATA_OFFSET, 32'h0000_0000);
    `CHK(rd[7:0], exp_q.pop_front())
    apb(1, spr_pkg::SPR_STATUS_OFFSET, 32'h0000_0001);
    // Multi-master mode: a falling select drops the master and raises the fault.
    apb(1, spr_pkg::SPR_CTRL_OFFSET, 32'h0000_0007);
    wt(2);
    `CHK(mosi_oe_n, 1'b0)
    far.drive_sel(1'b1, 1'b0);
    wt(8);
    far.drive_sel(1'b0, 1'b1);
    @(posedge pclk);
    `CHK({irq, mosi_oe_n, sck_oe_n}, 3'b111)
    apb(0, spr_pkg::SPR_CTRL_OFFSET, 32'h0000_0000);
    `CHK(rd[3:0], 4'h4)
    apb(0, spr_pkg::SPR_STATUS_OFFSET, 32'h0000_0000);
    `CHK(rd[1:0], 2'b10)
    apb(1, spr_pkg::SPR_STATUS_OFFSET, 32'h0000_0002);
    wt(2);
    `CHK(irq, 1'b0)
    wrap_up();
  end
endmodule
`default_nettype wire
